/* File: core/gtm_timer.v */
// gated elapsed timer core with nine operating modes and apb registers
`timescale 1ns/1ps
`include "gtm_consts.vh"

// Function
// - nine modes; all count up except the two down-timing modes
// - accumulate mode: input inactive stops counting, value stays shown
// - accumulate mode: input active resumes from the held value
// - input-length mode: inactive input resets to zero or preset
// - input-length mode: activation starts counting from zero or preset
// - repeating pulse: while inactive, shows the last completed pulse length
// - repeating pulse: each activation clears to zero, ignores preset, times pulse
// - single-shot pulse: if reset beforehand, activation starts from zero or preset
// - single-shot pulse: without a reset, new activation leaves value unchanged
// - held repeating pulse: shown value updates only when the pulse ends or on a reset or preset load
// - held single-shot: as single-shot, shown value updates only at pulse end or on a reset or preset load
// - start/stop up: activation starts; counting stops on stop input or a reset, not on deactivation
// - start/stop up: reset loads zero or preset per setting; restart without reset continues
// - start/stop down: like up timer but decrements, starts from preset
// - gated down: active input counts down from preset or held value
// - gated down: inactive input holds; preset operation, or a reset set to preset, restores preset
// - reset loads zero or preset per setting, preset always in start/stop down; hardware reset follows it
// - down modes: stop-at-zero halts at zero, else runs into negatives
module gtm_timer
#(
  parameter CW = 32,
  parameter TICK_CYCLES = `GTM_TICK_CYCLES
)
(
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire TIMING_IN,
  input wire STOP_IN,
  input wire RESET_IN,
  output reg [CW-1:0] ELAPSED,
  output reg RUNNING
);

  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // mode lookups used by several processes
  function is_down;
    input [3:0] m;
    begin
      is_down = (m == `GTM_MODE_START_STOP_DOWN) || (m == `GTM_MODE_GATED_DOWN);
    end
  endfunction

  function is_held;
    input [3:0] m;
    begin
      is_held = (m == `GTM_MODE_HELD_REPEATING_PULSE) ||
                (m == `GTM_MODE_HELD_SINGLE_SHOT_PULSE);
    end
  endfunction

  function is_known;
    input [11:0] a;
    begin
      is_known = (a == `GTM_CTRL_OFFSET) || (a == `GTM_PRESET_OFFSET) ||
                 (a == `GTM_CMD_OFFSET) || (a == `GTM_STATUS_OFFSET) ||
                 (a == `GTM_DISPLAY_OFFSET) || (a == `GTM_MEASURE_OFFSET);
    end
  endfunction

  // synchronised inputs and edge events
  wire timing_level;
  wire timing_rise;
  wire timing_fall;
  wire stop_rise;
  wire reset_rise;

  // timing, stop and reset pins each pass two flops first
  gtm_sync_edge u_sync_timing
  (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in(TIMING_IN),
    .level(timing_level),
    .rise(timing_rise),
    .fall(timing_fall)
  );

  // stop arrives on its own line, never folded into timing
  gtm_sync_edge u_sync_stop
  (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in(STOP_IN),
    .level(),
    .rise(stop_rise),
    .fall()
  );

  gtm_sync_edge u_sync_reset
  (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in(RESET_IN),
    .level(),
    .rise(reset_rise),
    .fall()
  );

  // registers
  reg [5:0] ctrl_reg;
  reg [CW-1:0] preset_reg;
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg signed [CW-1:0] measure_reg;
  reg signed [CW-1:0] measure_next;
  reg [CW-1:0] display_next;
  reg counting_reg;
  reg counting_next;
  reg armed_reg;
  reg armed_next;
  reg [31:0] rdata_next;

  wire [3:0] mode = ctrl_reg[`GTM_CTRL_MODE_MSB:`GTM_CTRL_MODE_LSB];
  wire rst_to_preset = ctrl_reg[`GTM_CTRL_RST_PRESET_BIT];
  wire stop_at_zero = ctrl_reg[`GTM_CTRL_STOP_ZERO_BIT];
  wire setup = PSEL & ~PENABLE;
  wire wr_done = PSEL & PENABLE & PREADY & PWRITE;
  wire ctrl_wr = wr_done && (PADDR == `GTM_CTRL_OFFSET);
  wire cmd_wr = wr_done && (PADDR == `GTM_CMD_OFFSET);
  wire soft_reset = cmd_wr & PWDATA[`GTM_CMD_RESET_BIT];
  wire preset_load = cmd_wr & PWDATA[`GTM_CMD_PRESET_BIT];
  wire any_reset = reset_rise | soft_reset;
  wire down = is_down(mode);
  wire at_zero = (measure_reg == {CW{1'b0}});
  // reset target follows the setting; start/stop down always reloads preset
  wire [CW-1:0] reset_val = (rst_to_preset || mode == `GTM_MODE_START_STOP_DOWN) ?
                            preset_reg : {CW{1'b0}};

  // apb slave: zero-wait answer, pready raised from the setup cycle
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      ctrl_reg <= `GTM_CTRL_RESET;
      preset_reg <= `GTM_PRESET_RESET;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup & ~is_known(PADDR);
      if (setup)
        PRDATA <= rdata_next;
      // unknown mode codes are dropped so the core never sees them
      if (ctrl_wr)
      begin
        if (PWDATA[`GTM_CTRL_MODE_MSB:`GTM_CTRL_MODE_LSB] <= `GTM_MODE_LAST)
          ctrl_reg <= PWDATA[5:0];
        else
          ctrl_reg <= {PWDATA[5:4], mode};
      end
      if (wr_done && PADDR == `GTM_PRESET_OFFSET)
        preset_reg <= PWDATA[CW-1:0];
    end
  end

  // read mux, sampled during setup so data stands through the access phase
  always @*
  begin
    rdata_next = 32'h00000000;
    case (PADDR)
      `GTM_CTRL_OFFSET: rdata_next = {26'h0000000, ctrl_reg};
      `GTM_PRESET_OFFSET: rdata_next = preset_reg;
      `GTM_STATUS_OFFSET:
      begin
        rdata_next[`GTM_STAT_COUNTING_BIT] = counting_reg;
        rdata_next[`GTM_STAT_ARMED_BIT] = armed_reg;
        rdata_next[`GTM_STAT_TIMING_BIT] = timing_level;
        rdata_next[`GTM_STAT_AT_ZERO_BIT] = at_zero;
        rdata_next[`GTM_STAT_MODE_MSB:`GTM_STAT_MODE_LSB] = mode;
      end
      `GTM_DISPLAY_OFFSET: rdata_next = ELAPSED;
      `GTM_MEASURE_OFFSET: rdata_next = measure_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // time base: one tick per time unit, free running so phase is not reset per pulse
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg >= TICK_LAST)
    begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  // mode behaviour: decides counting, arming and the measuring value
  always @*
  begin
    counting_next = counting_reg;
    armed_next = armed_reg;
    measure_next = measure_reg;
    // count step; down modes decrement, everything else counts up
    if (counting_reg && tick_reg)
    begin
      if (down)
      begin
        if (!(stop_at_zero && at_zero))
          measure_next = measure_reg - {{(CW-1){1'b0}}, 1'b1};
      end
      else
        measure_next = measure_reg + {{(CW-1){1'b0}}, 1'b1};
    end
    case (mode)
      `GTM_MODE_ACCUMULATE:
      begin
        // counting tracks the input, value kept between active periods
        counting_next = timing_level;
      end
      `GTM_MODE_INPUT_LENGTH:
      begin
        counting_next = timing_level;
        if (!timing_level)
          measure_next = reset_val;
        else if (timing_rise)
          measure_next = reset_val;
      end
      `GTM_MODE_REPEATING_PULSE, `GTM_MODE_HELD_REPEATING_PULSE:
      begin
        if (timing_rise)
        begin
          measure_next = {CW{1'b0}}; // preset ignored here
          counting_next = 1'b1;
        end
        else if (timing_fall)
          counting_next = 1'b0; // last pulse stays as the result
      end
      `GTM_MODE_SINGLE_SHOT_PULSE, `GTM_MODE_HELD_SINGLE_SHOT_PULSE:
      begin
        if (timing_rise && armed_reg)
        begin
          measure_next = reset_val;
          counting_next = 1'b1;
          armed_next = 1'b0;
        end
        else if (timing_fall)
          counting_next = 1'b0;
        // unarmed activation changes nothing
      end
      `GTM_MODE_START_STOP_UP, `GTM_MODE_START_STOP_DOWN:
      begin
        // stop wins if both edges meet in one cycle
        if (stop_rise)
          counting_next = 1'b0;
        else if (timing_rise)
          counting_next = 1'b1; // continues from held value
        if (down && stop_at_zero && at_zero)
          counting_next = 1'b0;
      end
      `GTM_MODE_GATED_DOWN:
      begin
        // holds while inactive, counts down while active
        counting_next = timing_level;
      end
      default:
      begin
        counting_next = 1'b0;
      end
    endcase
    // explicit preset restores the preset value
    if (preset_load)
      measure_next = preset_reg;
    // reset pin and soft reset load zero or preset and re-arm
    if (any_reset)
    begin
      measure_next = reset_val;
      armed_next = 1'b1;
      if (mode != `GTM_MODE_ACCUMULATE && mode != `GTM_MODE_INPUT_LENGTH &&
          mode != `GTM_MODE_GATED_DOWN)
        counting_next = 1'b0;
    end
    // a mode change abandons any run in progress
    if (ctrl_wr)
      counting_next = 1'b0;
  end

  // displayed value: live for most modes, captured at pulse end for held ones
  always @*
  begin
    display_next = ELAPSED;
    if (!is_held(mode))
      display_next = measure_next;
    else if (timing_fall && counting_reg)
      display_next = measure_reg;
    else if (any_reset || preset_load)
      display_next = measure_next;
  end

  // state registers and outputs, all straight from flops
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      measure_reg <= {CW{1'b0}};
      counting_reg <= 1'b0;
      armed_reg <= 1'b1;
      ELAPSED <= {CW{1'b0}};
      RUNNING <= 1'b0;
    end
    else
    begin
      measure_reg <= measure_next;
      counting_reg <= counting_next;
      armed_reg <= armed_next;
      ELAPSED <= display_next;
      RUNNING <= counting_next;
    end
  end

endmodule

/* File: include/gtm_consts.vh */
// constants for the gated elapsed timer: register map, fields, resets, timing
`ifndef GTM_CONSTS_VH
`define GTM_CONSTS_VH

// register byte offsets on the apb bus
`define GTM_CTRL_OFFSET 12'h000
`define GTM_PRESET_OFFSET 12'h004
`define GTM_CMD_OFFSET 12'h008
`define GTM_STATUS_OFFSET 12'h00c
`define GTM_DISPLAY_OFFSET 12'h010
`define GTM_MEASURE_OFFSET 12'h014

// control register fields
`define GTM_CTRL_MODE_LSB 0
`define GTM_CTRL_MODE_MSB 3
`define GTM_CTRL_RST_PRESET_BIT 4
`define GTM_CTRL_STOP_ZERO_BIT 5

// command register fields (write only, self clearing)
`define GTM_CMD_RESET_BIT 0
`define GTM_CMD_PRESET_BIT 1

// status register fields
`define GTM_STAT_COUNTING_BIT 0
`define GTM_STAT_ARMED_BIT 1
`define GTM_STAT_TIMING_BIT 2
`define GTM_STAT_AT_ZERO_BIT 3
`define GTM_STAT_MODE_LSB 4
`define GTM_STAT_MODE_MSB 7

// reset values
`define GTM_CTRL_RESET 6'h00
`define GTM_PRESET_RESET 32'h00000000

// operating mode codes
`define GTM_MODE_ACCUMULATE 4'h0
`define GTM_MODE_INPUT_LENGTH 4'h1
`define GTM_MODE_REPEATING_PULSE 4'h2
`define GTM_MODE_SINGLE_SHOT_PULSE 4'h3
`define GTM_MODE_HELD_REPEATING_PULSE 4'h4
`define GTM_MODE_HELD_SINGLE_SHOT_PULSE 4'h5
`define GTM_MODE_START_STOP_UP 4'h6
`define GTM_MODE_START_STOP_DOWN 4'h7
`define GTM_MODE_GATED_DOWN 4'h8
`define GTM_MODE_LAST 4'h8

// timing: one count step per time unit
`define GTM_CLK_PERIOD_NS 4
`define GTM_TICK_NS 1000000
`define GTM_TICK_CYCLES (`GTM_TICK_NS / `GTM_CLK_PERIOD_NS)

`endif

/* File: core/gtm_sync_edge.v */
// two-flop synchroniser with activation and deactivation edge pulses
`timescale 1ns/1ps

module gtm_sync_edge
(
  input wire clk,
  input wire rst_n,
  input wire async_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // meta_reg feeds only sync_reg; edges are taken from the later stages
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // single-cycle events for the mode logic
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule

/* File: sim/gtm_timer_monitor.sv */
// port-level checker for the gated elapsed timer
`timescale 1ns/1ps
module gtm_timer_monitor
#(
  parameter CW = 32
)
(
  input wire CLK,
  input wire RST_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire TIMING_IN,
  input wire STOP_IN,
  input wire RESET_IN,
  input wire [CW-1:0] ELAPSED,
  input wire RUNNING
);
  logic [3:0] mode_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // shadow of the mode field; codes above eight are refused by the core
  always @(posedge CLK)
    if (!RST_N)
      mode_reg <= 4'h0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000 && PWDATA[3:0] <= 4'h8)
      mode_reg <= PWDATA[3:0];
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  reset_zero_a: assert property ($rose(RST_N) |-> ELAPSED == 0 && !RUNNING)
    else $error("count not clear after reset");
  acc_start_a: assert property (mode_reg == 4'h0 && $rose(TIMING_IN) |-> ##[2:6] RUNNING)
    else $error("accumulate did not resume");
  acc_stop_a: assert property (mode_reg == 4'h0 && $fell(TIMING_IN) |-> ##[2:6] !RUNNING)
    else $error("accumulate did not stop");
  stop_halt_a: assert property (mode_reg == 4'h6 && $rose(STOP_IN) |-> ##[2:6] !RUNNING)
    else $error("stop input ignored");
  held_show_a: assert property (mode_reg == 4'h4 && RUNNING && $past(RUNNING) |-> $stable(ELAPSED))
    else $error("held display moved mid pulse");
  down_step_a: assert property (mode_reg == 4'h7 && RUNNING && $past(RUNNING)
    |-> $signed(ELAPSED) <= $signed($past(ELAPSED)))
    else $error("down timer counted up");
endmodule

bind gtm_timer gtm_timer_monitor #(.CW(CW)) gtm_timer_monitor_inst (.CLK, .RST_N, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TIMING_IN, .STOP_IN, .RESET_IN,
  .ELAPSED, .RUNNING);

/* File: sim/gtm_source.sv */
// model of the outside timing, stop and reset sources
`timescale 1ns/1ps
module gtm_source
(
  input wire clk,
  output logic timing,
  output logic stop,
  output logic reset
);
  // all lines idle low from time zero
  initial {timing, stop, reset} = 3'b000;
  // timing level held exactly n cycles when the next call follows at once,
  // so a pulse spans whole tick periods whatever the free running tick phase
  task level(input logic v, input int n);
    timing <= v;
    repeat (n) @(posedge clk);
  endtask
  // stop rides its own line, apart from timing; held long enough to survive the sync
  task kick(input logic s);
    @(posedge clk);
    if (s) stop <= 1'b1;
    else reset <= 1'b1;
    repeat (3) @(posedge clk);
    {stop, reset} <= 2'b00;
  endtask
endmodule

/* File: sim/tb_gated_elapsed_timer_modes.sv */
// self-checking bench for the gated elapsed timer
`timescale 1ns/1ps
`include "gtm_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_gated_elapsed_timer_modes;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd, w;
  logic PREADY, PSLVERR, er, TIMING_IN, STOP_IN, RESET_IN, RUNNING;
  logic [31:0] ELAPSED;
  int mismatches = 0, n_checks = 0, v;
  // short tick keeps each count step four clocks
  gtm_timer #(.CW(32), .TICK_CYCLES(4)) gtm_timer_inst (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TIMING_IN, .STOP_IN, .RESET_IN, .ELAPSED,
    .RUNNING);
  gtm_source gtm_source_inst (.clk(CLK), .timing(TIMING_IN), .stop(STOP_IN), .reset(RESET_IN));
  initial forever #2 CLK = ~CLK;
  task summarize;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; the wait for ready is bounded
  task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr_en, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin @(posedge CLK); k++; end while (PREADY !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      mismatches++;
      summarize;
    end
    else
    begin
      rd = PRDATA;
      er = PSLVERR;
      {PSEL, PENABLE} <= 2'b00;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e);
    `CHK(er, ee);
  endtask
  // select a mode, then soft reset so single-shot modes are armed
  task mode(input logic [31:0] c);
    wr(`GTM_CTRL_OFFSET, c);
    wr(`GTM_CMD_OFFSET, 32'h1);
  endtask
  // count within one step, since the tick phase is free running
  task near(input int e);
    repeat (2) @(posedge CLK);
    v = int'(ELAPSED) - e;
    `CHK(v inside {[-1:1]}, 1'b1);
  endtask
  task t_regs;
    rdc(`GTM_CTRL_OFFSET, 32'h0, 1'b0);
    wr(`GTM_CTRL_OFFSET, 32'h1f);
    rdc(`GTM_CTRL_OFFSET, 32'h10, 1'b0);
    rdc(12'h020, 32'h0, 1'b1);
    for (int m = 0; m < 9; m++)
    begin
      wr(`GTM_CTRL_OFFSET, m);
      rdc(`GTM_CTRL_OFFSET, m, 1'b0);
    end
  endtask
  task t_accum;
    mode(32'h0);
    gtm_source_inst.level(1, 40);
    gtm_source_inst.level(0, 20);
    near(10);
    gtm_source_inst.level(1, 40);
    gtm_source_inst.level(0, 12);
    near(20);
  endtask
  task t_length;
    wr(`GTM_PRESET_OFFSET, 32'd100);
    mode(32'h11);
    gtm_source_inst.level(1, 40);
    near(109);
    gtm_source_inst.level(0, 12);
    near(100);
  endtask
  task t_pulse;
    mode(32'h12);
    gtm_source_inst.level(1, 40);
    gtm_source_inst.level(0, 12);
    near(10);
    gtm_source_inst.level(1, 24);
    near(5);
    gtm_source_inst.level(0, 12);
  endtask
  task t_single;
    mode(32'h3);
    repeat (2)
    begin
      gtm_source_inst.level(1, 40);
      gtm_source_inst.level(0, 12);
      near(10);
    end
    gtm_source_inst.kick(0);
    repeat (8) @(posedge CLK);
    `CHK(ELAPSED, 32'h0);
    gtm_source_inst.level(1, 24);
    gtm_source_inst.level(0, 12);
    near(6);
  endtask
  task t_held;
    for (int m = 4; m < 6; m++)
    begin
      mode(m);
      gtm_source_inst.level(1, 40);
      gtm_source_inst.level(0, 12);
      near(10);
      if (m == 5) wr(`GTM_CMD_OFFSET, 32'h1);
      gtm_source_inst.level(1, 80);
      near(m == 4 ? 10 : 0);
      gtm_source_inst.level(0, 12);
      near(20);
    end
  endtask
  task t_updown;
    mode(32'h6);
    gtm_source_inst.level(1, 8);
    gtm_source_inst.level(0, 40);
    `CHK(RUNNING, 1'b1);
    gtm_source_inst.kick(1);
    repeat (8) @(posedge CLK);
    `CHK(RUNNING, 1'b0);
    w = ELAPSED;
    gtm_source_inst.level(1, 8);
    gtm_source_inst.level(0, 20);
    `CHK($signed(ELAPSED) > $signed(w), 1'b1);
    gtm_source_inst.kick(0);
    repeat (8) @(posedge CLK);
    `CHK(ELAPSED, 32'h0);
    wr(`GTM_PRESET_OFFSET, 32'd5);
    mode(32'h27);
    near(5);
    gtm_source_inst.level(1, 8);
    gtm_source_inst.level(0, 60);
    `CHK(ELAPSED, 32'h0);
    mode(32'h7);
    gtm_source_inst.level(1, 8);
    gtm_source_inst.level(0, 60);
    `CHK(ELAPSED[31], 1'b1);
  endtask
  task t_gated;
    wr(`GTM_PRESET_OFFSET, 32'd50);
    mode(32'h18);
    gtm_source_inst.level(1, 40);
    gtm_source_inst.level(0, 32);
    near(40);
    gtm_source_inst.level(1, 40);
    gtm_source_inst.level(0, 12);
    near(30);
    wr(`GTM_CMD_OFFSET, 32'h2);
    near(50);
  endtask
  // reset for three cycles, then every scenario in turn
  initial
  begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    t_regs;
    t_accum;
    t_length;
    t_pulse;
    t_single;
    t_held;
    t_updown;
    t_gated;
    summarize;
  end
endmodule
